// ==== common/fault_log_map.svh ====
`ifndef FAULT_LOG_MAP_SVH
`define FAULT_LOG_MAP_SVH

// Record layout, in record byte numbers
`define FL_BYTE_COUNT 8'hFF
`define FL_IDX_POS_LAST 8'h00
`define FL_IDX_VALID_CNT 8'h01
`define FL_IDX_PEAK6 8'h28
`define FL_IDX_STATUS0 8'h30
`define FL_IDX_CYCLIC 8'h48
`define FL_IDX_CYCLIC_LAST 8'hED
`define FL_IDX_LAST 8'hFE
`define FL_CYCLIC_BYTES 8'hA6
`define FL_ALL_VALID 8'hFF
`define FL_RESERVED_BYTE 8'h00

// Loop layout
`define FL_LOOP_BYTES 6'h2E
`define FL_LOOP_LAST_POS 6'h2D
`define FL_POS_VIN 6'h0A
`define FL_POS_CH2 6'h0D
`define FL_POS_TEMP 6'h17
`define FL_POS_CH4 6'h1A

// Ring memory: four whole loops
`define FL_RING_DEPTH 184
`define FL_RING_LAST 8'hB7

`endif

// ==== common/fault_log_pkg.sv ====
package fault_log_pkg;

	// One conversion's worth of telemetry
	typedef struct packed {
		logic [7:0][15:0] read_vout;
		logic [7:0][7:0] status_vout;
		logic [7:0][7:0] status_mfr;
		logic [7:0][15:0] status_ext;
		logic [15:0] read_vin;
		logic [7:0] status_vin;
		logic [15:0] read_temp;
		logic [7:0] status_temp;
	} telemetry_t;

	// Peak and minimum of the last two channels
	typedef struct packed {
		logic [1:0][15:0] vout_peak;
		logic [1:0][15:0] vout_min;
	} extremes_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_COUNT = 2'b01,
		RD_DATA = 2'b10
	} read_state_t;

	typedef enum logic {
		WR_IDLE = 1'b0,
		WR_LOOP = 1'b1
	} write_state_t;

endpackage : fault_log_pkg

// ==== verilog/fault_log_ring.sv ====
`timescale 1ns/10ps
`default_nettype none

`include "fault_log_map.svh"

module fault_log_ring (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	// Write port
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	// Read port
	input wire logic rd_en,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data
);

	logic [7:0] mem [0:`FL_RING_DEPTH-1];

	always_ff @(posedge clk) begin
		if (ce && wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data <= 8'h00;
		end else if (ce && rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule : fault_log_ring

`default_nettype wire

// ==== verilog/fault_log_readout.sv ====
`timescale 1ns/10ps
`default_nettype none

`include "fault_log_map.svh"

module fault_log_readout
	import fault_log_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	// Telemetry side
	input wire logic conv_done,
	input wire telemetry_t conv_data,
	input wire extremes_t extremes,
	input wire logic log_lock,
	// Block read side
	input wire logic rd_start,
	input wire logic byte_req,
	output logic [7:0] byte_data,
	output logic byte_valid,
	output logic byte_last,
	// Status
	output logic loop_busy
);

	// ********************************
	// Loop formatting
	// ********************************

	// Byte at a given loop position of one conversion
	function automatic logic [7:0] loop_byte(input telemetry_t t, input logic [5:0] pos);
		logic [5:0] rel;
		logic [2:0] ch;
		logic [2:0] slot;
		logic [15:0] word;
		rel = pos;
		ch = 3'd0;
		slot = 3'd0;
		word = 16'h0000;
		loop_byte = 8'h00;
		if (pos >= `FL_POS_VIN && pos < `FL_POS_CH2) begin
			word = t.read_vin;
			loop_byte = (pos == `FL_POS_VIN + 6'h02) ? t.status_vin :
				(pos == `FL_POS_VIN) ? word[7:0] : word[15:8];
		end else if (pos >= `FL_POS_TEMP && pos < `FL_POS_CH4) begin
			word = t.read_temp;
			loop_byte = (pos == `FL_POS_TEMP + 6'h02) ? t.status_temp :
				(pos == `FL_POS_TEMP) ? word[7:0] : word[15:8];
		end else begin
			if (pos >= `FL_POS_CH4) begin
				rel = pos - `FL_POS_CH4 + 6'h14;
			end else if (pos >= `FL_POS_CH2) begin
				rel = pos - `FL_POS_CH2 + 6'h0A;
			end
			ch = 3'(rel / 6'h05);
			slot = 3'(rel % 6'h05);
			word = t.read_vout[ch];
			case (slot)
				3'd0: loop_byte = word[7:0];
				3'd1: loop_byte = word[15:8];
				3'd2: loop_byte = t.status_vout[ch];
				3'd3: loop_byte = t.status_mfr[ch];
				// Upper reserved half is dropped
				default: loop_byte = t.status_ext[ch][7:0];
			endcase
		end
	endfunction : loop_byte

	// ********************************
	// Conversion capture and ring writes
	// ********************************

	write_state_t wr_state_reg;
	telemetry_t conv_reg;
	logic [5:0] wr_pos_reg;
	logic [7:0] wr_addr_reg;
	logic [7:0] last_addr_reg;
	logic [5:0] last_pos_reg;
	logic [7:0] valid_cnt_reg;
	logic wr_en;

	assign wr_en = (wr_state_reg == WR_LOOP) && !log_lock;
	assign loop_busy = (wr_state_reg == WR_LOOP);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_state_reg <= WR_IDLE;
			wr_pos_reg <= 6'h00;
			conv_reg <= '0;
		end else if (ce) begin
			case (wr_state_reg)
				WR_IDLE: begin
					if (conv_done && !log_lock) begin
						conv_reg <= conv_data;
						wr_pos_reg <= 6'h00;
						wr_state_reg <= WR_LOOP;
					end
				end
				default: begin
					if (log_lock || wr_pos_reg == `FL_LOOP_LAST_POS) begin
						wr_state_reg <= WR_IDLE;
					end else begin
						wr_pos_reg <= wr_pos_reg + 6'h01;
					end
				end
			endcase
		end
	end

	// Ring pointer and the pointer snapshot that the lock freezes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_addr_reg <= 8'h00;
			last_addr_reg <= `FL_RING_LAST;
			last_pos_reg <= `FL_LOOP_LAST_POS;
		end else if (ce && wr_en) begin
			last_addr_reg <= wr_addr_reg;
			last_pos_reg <= wr_pos_reg;
			wr_addr_reg <= (wr_addr_reg == `FL_RING_LAST) ? 8'h00 : wr_addr_reg + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			valid_cnt_reg <= 8'h00;
		end else if (ce && wr_en && valid_cnt_reg != `FL_CYCLIC_BYTES) begin
			valid_cnt_reg <= valid_cnt_reg + 8'h01;
		end
	end

	// ********************************
	// Block read sequencing
	// ********************************

	read_state_t rd_state_reg;
	logic [7:0] idx_reg;
	logic [7:0] rd_ptr_reg;
	logic pend_reg;
	logic pend_count_reg;
	logic [7:0] pend_idx_reg;
	logic in_cyclic;
	logic [7:0] ring_data;
	logic [7:0] pre_byte;

	assign in_cyclic = (idx_reg >= `FL_IDX_CYCLIC) && (idx_reg <= `FL_IDX_CYCLIC_LAST);

	fault_log_ring ring (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.wr_en(wr_en),
		.wr_addr(wr_addr_reg),
		.wr_data(loop_byte(conv_reg, wr_pos_reg)),
		.rd_en(byte_req && rd_state_reg == RD_DATA && in_cyclic),
		.rd_addr(rd_ptr_reg),
		.rd_data(ring_data)
	);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_state_reg <= RD_IDLE;
			idx_reg <= 8'h00;
			rd_ptr_reg <= 8'h00;
		end else if (ce) begin
			if (rd_start) begin
				rd_state_reg <= RD_COUNT;
				idx_reg <= `FL_IDX_POS_LAST;
				rd_ptr_reg <= last_addr_reg;
			end else if (byte_req) begin
				case (rd_state_reg)
					RD_COUNT: rd_state_reg <= RD_DATA;
					RD_DATA: begin
						if (idx_reg == `FL_IDX_LAST) begin
							rd_state_reg <= RD_IDLE;
						end
						idx_reg <= idx_reg + 8'h01;
						// Step back, wrap into older loop
						if (in_cyclic) begin
							rd_ptr_reg <= (rd_ptr_reg == 8'h00) ? `FL_RING_LAST :
								rd_ptr_reg - 8'h01;
						end
					end
					default: rd_state_reg <= RD_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_reg <= 1'b0;
			pend_count_reg <= 1'b0;
			pend_idx_reg <= 8'h00;
		end else if (ce) begin
			pend_reg <= byte_req && !rd_start && rd_state_reg != RD_IDLE;
			pend_count_reg <= (rd_state_reg == RD_COUNT);
			pend_idx_reg <= idx_reg;
		end
	end

	always_comb begin
		logic [7:0] k;
		logic [2:0] ch;
		logic [1:0] r;
		logic [15:0] w;
		k = 8'h00;
		ch = 3'd0;
		r = 2'd0;
		w = 16'h0000;
		pre_byte = 8'h00;
		if (pend_idx_reg == `FL_IDX_POS_LAST) begin
			pre_byte = {2'b00, last_pos_reg};
		end else if (pend_idx_reg == `FL_IDX_VALID_CNT) begin
			// Full area reads as all valid
			pre_byte = (valid_cnt_reg == `FL_CYCLIC_BYTES) ? `FL_ALL_VALID : valid_cnt_reg;
		end else if (pend_idx_reg >= `FL_IDX_PEAK6 && pend_idx_reg < `FL_IDX_STATUS0) begin
			k = pend_idx_reg - `FL_IDX_PEAK6;
			w = k[1] ? extremes.vout_min[k[2]] : extremes.vout_peak[k[2]];
			pre_byte = k[0] ? w[15:8] : w[7:0];
		end else if (pend_idx_reg >= `FL_IDX_STATUS0 && pend_idx_reg < `FL_IDX_CYCLIC) begin
			k = pend_idx_reg - `FL_IDX_STATUS0;
			ch = 3'(k / 8'h03);
			r = 2'(k % 8'h03);
			case (r)
				2'd0: pre_byte = conv_reg.status_vout[ch];
				2'd1: pre_byte = conv_reg.status_mfr[ch];
				default: pre_byte = conv_reg.status_ext[ch][7:0];
			endcase
		end
	end

	// ********************************
	// Byte output
	// ********************************

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			byte_data <= 8'h00;
			byte_valid <= 1'b0;
			byte_last <= 1'b0;
		end else if (ce) begin
			byte_valid <= pend_reg;
			byte_last <= pend_reg && !pend_count_reg && pend_idx_reg == `FL_IDX_LAST;
			if (pend_reg) begin
				if (pend_count_reg) begin
					byte_data <= `FL_BYTE_COUNT;
				end else if (pend_idx_reg >= `FL_IDX_CYCLIC &&
					pend_idx_reg <= `FL_IDX_CYCLIC_LAST) begin
					byte_data <= ring_data;
				end else if (pend_idx_reg > `FL_IDX_CYCLIC_LAST) begin
					byte_data <= `FL_RESERVED_BYTE;
				end else begin
					byte_data <= pre_byte;
				end
			end
		end
	end

endmodule : fault_log_readout

`default_nettype wire

// ==== dv/host_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// ********
// Block read host
// ********
module host_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Request and answer
	output logic rd_start,
	output logic byte_req,
	input wire logic [7:0] byte_data,
	input wire logic byte_valid,
	input wire logic byte_last
);
	logic [7:0] rec [0:255];
	logic last_flag [0:255];
	int cnt;

	initial begin
		rd_start = 1'b0;
		byte_req = 1'b0;
	end

	task automatic start();
		rd_start <= 1'b1;
		@(posedge clk);
		rd_start <= 1'b0;
	endtask : start

	// Idle gap between requests models a slow host
	task automatic req(input int n, input int gap);
		for (int i = 0; i < n; i++) begin
			byte_req <= 1'b1;
			@(posedge clk);
			if (gap > 0) begin
				byte_req <= 1'b0;
				repeat (gap) @(posedge clk);
			end
		end
		byte_req <= 1'b0;
	endtask : req

	// Count byte first
	// Slot 0 holds the count byte, so record byte n lands in slot n+1
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b || rd_start)
			cnt <= 0;
		else if (byte_valid) begin
			rec[cnt] <= byte_data;
			last_flag[cnt] <= byte_last;
			cnt <= cnt + 1;
		end
	end
endmodule : host_model

`default_nettype wire

// ==== dv/fault_log_readout_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none

// ********
// Readout checks
// ********
module fault_log_readout_assertions (
	// Clock, reset and inputs
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic conv_done,
	input wire logic log_lock,
	input wire logic rd_start,
	input wire logic byte_req,
	// Outputs
	input wire logic [7:0] byte_data,
	input wire logic byte_valid,
	input wire logic byte_last,
	input wire logic loop_busy
);
	logic [5:0] busy_cnt;
	logic [8:0] sent;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			busy_cnt <= 6'h00;
		else
			busy_cnt <= loop_busy ? busy_cnt + 6'(ce) : 6'h00;
	end

	// Answers since the last start; the count byte is answer 0
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			sent <= 9'h000;
		else if (rd_start || byte_valid)
			sent <= rd_start ? 9'h000 : sent + 9'h001;
	end

	sequence s_first_req;
		rd_start && ce ##1 byte_req && ce && !rd_start ##1 ce;
	endsequence

	a_count_byte: assert property (s_first_req |=> byte_valid && byte_data == 8'hFF)
		else $error("count byte missing");
	a_answer_cause: assert property (byte_valid && $past(ce) && $past(ce, 2) |-> $past(byte_req, 2))
		else $error("answer without request");
	a_last_place: assert property (byte_valid |-> byte_last == (sent == 9'h0FF))
		else $error("last flag misplaced");
	a_reserved_zero: assert property (byte_valid && sent > 9'h0EE |-> byte_data == 8'h00)
		else $error("reserved byte not zero");
	a_loop_start: assert property (conv_done && ce && !log_lock && !loop_busy |=> loop_busy)
		else $error("conversion not logged");
	a_lock_blocks: assert property (log_lock && !loop_busy |=> !loop_busy)
		else $error("write while locked");
	a_loop_length: assert property ($fell(loop_busy) && !log_lock |-> busy_cnt == 6'h2E)
		else $error("loop length wrong");
	a_loop_holds: assert property (loop_busy && busy_cnt < 6'h2D |=> loop_busy || log_lock)
		else $error("loop ended early");
endmodule : fault_log_readout_assertions

bind fault_log_readout fault_log_readout_assertions u_fault_log_readout_assertions (
	.clk(clk), .rst_b(rst_b), .ce(ce), .conv_done(conv_done), .log_lock(log_lock),
	.rd_start(rd_start), .byte_req(byte_req), .byte_data(byte_data),
	.byte_valid(byte_valid), .byte_last(byte_last), .loop_busy(loop_busy));

`default_nettype wire

// ==== dv/tb_fault_log_readout.sv ====
`timescale 1ns/10ps
`default_nettype none

// ********
// Readout bench
// ********
module tb_fault_log_readout
	import fault_log_pkg::*;
;
	logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, conv_done = 1'b0, log_lock = 1'b0;
	logic rd_start, byte_req, byte_valid, byte_last, loop_busy;
	logic [7:0] byte_data;
	telemetry_t conv_data = '0;
	extremes_t extremes = 64'h8877_6655_4433_2211;
	telemetry_t tm [1:4];
	int error_cnt, comparisons, cycles;

	fault_log_readout u_fault_log_readout (.clk(clk), .rst_b(rst_b), .ce(ce),
		.conv_done(conv_done), .conv_data(conv_data), .extremes(extremes),
		.log_lock(log_lock), .rd_start(rd_start), .byte_req(byte_req), .byte_data(byte_data),
		.byte_valid(byte_valid), .byte_last(byte_last), .loop_busy(loop_busy));
	host_model u_host_model (.clk(clk), .rst_b(rst_b), .rd_start(rd_start),
		.byte_req(byte_req), .byte_data(byte_data), .byte_valid(byte_valid),
		.byte_last(byte_last));

	always #5 clk = ~clk;

	// Whole run needs about 1800 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			error_cnt++;
			summarize();
		end
	end

	task automatic summarize();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// Distinct bytes everywhere, extended status high bytes included
	function automatic telemetry_t mk(input int k);
		telemetry_t t;
		for (int i = 0; i < 54; i++)
			t[i * 8 +: 8] = 8'(k * 60 + i);
		return t;
	endfunction : mk

	function automatic logic [7:0] loop_byte(input telemetry_t t, input int p);
		int b;
		logic [39:0] g;
		if (p inside {[10:12]})
			return 8'({t.status_vin, t.read_vin} >> (p - 10) * 8);
		if (p inside {[23:25]})
			return 8'({t.status_temp, t.read_temp} >> (p - 23) * 8);
		b = p < 10 ? 0 : (p < 23 ? 13 : 26);
		g = {t.status_ext[(p - b) / 5 + b / 6][7:0], t.status_mfr[(p - b) / 5 + b / 6],
			t.status_vout[(p - b) / 5 + b / 6], t.read_vout[(p - b) / 5 + b / 6]};
		return g[(p - b) % 5 * 8 +: 8];
	endfunction : loop_byte

	// Bit 8 set means the byte is not checked
	function automatic logic [8:0] expect_byte(input int n, input int b);
		int v;
		int i;
		logic [15:0] w;
		v = n * 46;
		i = b - 48;
		w = b % 4 < 2 ? extremes.vout_peak[b / 4 - 10] : extremes.vout_min[b / 4 - 10];
		if (b == 0)
			return 9'h02D;
		if (b == 1)
			return v >= 166 ? 9'h0FF : 9'(v);
		if (b < 40)
			return 9'h100;
		if (b < 48)
			return {1'b0, 8'(w >> b % 2 * 8)};
		if (b < 72)
			return {1'b0, loop_byte(tm[n], i / 3 * 5 + (i > 5 ? 3 : 0) + (i > 11 ? 3 : 0) + 2 + i % 3)};
		if (b < 238)
			return b < 72 + v ? {1'b0, loop_byte(tm[n - (b - 72) / 46], 45 - (b - 72) % 46)} : 9'h100;
		return 9'h000;
	endfunction : expect_byte

	task automatic read_chk(input int n, input int gap);
		logic [8:0] e;
		u_host_model.start();
		u_host_model.req(257, gap);
		repeat (4) @(posedge clk);
		chk("count", 16'h00FF, u_host_model.rec[0]);
		for (int b = 0; b < 255; b++) begin
			e = expect_byte(n, b);
			if (!e[8])
				chk($sformatf("byte %0d", b), e, u_host_model.rec[b + 1]);
		end
		chk("last", 16'h1, u_host_model.last_flag[255]);
		chk("bytes", 16'h0100, 16'(u_host_model.cnt));
	endtask : read_chk

	task automatic conv(input int k);
		tm[k] = mk(k);
		conv_data <= tm[k];
		conv_done <= 1'b1;
		@(posedge clk);
		conv_done <= 1'b0;
		repeat (48) @(posedge clk);
		@(negedge clk);
		chk("busy", 16'h0, loop_busy);
		@(posedge clk);
	endtask : conv

	task automatic s_refuse();
		u_host_model.req(1, 0);
		repeat (4) @(posedge clk);
		chk("early", 16'h0, 16'(u_host_model.cnt));
		// Clock enable low freezes capture
		ce <= 1'b0;
		conv_data <= mk(9);
		conv_done <= 1'b1;
		@(posedge clk);
		conv_done <= 1'b0;
		repeat (2) @(negedge clk);
		chk("frozen", 16'h0, loop_busy);
		@(posedge clk);
		ce <= 1'b1;
	endtask : s_refuse

	task automatic s_one_loop();
		conv(1);
		read_chk(1, 0);
	endtask : s_one_loop

	task automatic s_lock();
		log_lock <= 1'b1;
		conv_data <= mk(7);
		conv_done <= 1'b1;
		@(posedge clk);
		conv_done <= 1'b0;
		repeat (3) @(negedge clk);
		chk("locked", 16'h0, loop_busy);
		@(posedge clk);
		log_lock <= 1'b0;
		read_chk(1, 2);
	endtask : s_lock

	task automatic s_wrap();
		for (int k = 2; k < 5; k++)
			conv(k);
		read_chk(4, 1);
	endtask : s_wrap

	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		s_refuse();
		s_one_loop();
		s_lock();
		s_wrap();
		summarize();
	end
endmodule : tb_fault_log_readout

`default_nettype wire
